// >>> design/rsse_pkg.sv
// Purpose: shared constants and types of the rotate, subtract and skip execution unit
// Assumes: 8-bit data path, one core clock, synchronous active-low reset
// Notes:   operation codes are assigned by the enum; the decoder uses these names
package rsse_pkg;

    // ==========================================================
    // widths and field positions
    localparam int RSSE_DATA_W  = 8;
    localparam int RSSE_MSB     = 7;
    localparam int RSSE_NIB     = 4;
    localparam int RSSE_SEL_W   = 3;

    // ==========================================================
    // values and reset values
    localparam logic [7:0] RSSE_ALL_ONES = 8'hFF;
    localparam logic [7:0] RSSE_ZERO     = 8'h00;
    localparam logic [7:0] RSSE_ONE      = 8'h01;
    localparam logic [3:0] RSSE_NIB_ZERO = 4'h0;
    localparam logic [7:0] RSSE_ACC_RST  = 8'h00;

    // ==========================================================
    // operations
    typedef enum logic [4:0] {
        rotate_left,
        rotate_left_to_work,
        rotate_left_via_carry,
        rotate_left_via_carry_to_work,
        rotate_right,
        rotate_right_to_work,
        rotate_right_via_carry,
        rotate_right_via_carry_to_work,
        minus_work,
        minus_imm,
        minus_to_mem,
        borrow_minus,
        borrow_minus_imm,
        borrow_minus_to_mem,
        dec_skip_zero,
        dec_skip_zero_to_work,
        inc_skip_zero,
        inc_skip_zero_to_work,
        skip_if_nonzero_bit,
        skip_if_zero_bit,
        skip_if_nonzero,
        skip_if_zero,
        copy_skip_zero,
        set_byte,
        set_bit,
        nibble_exchange,
        nibble_exchange_to_work
    } rsse_op_t;

    typedef struct packed {
        logic                  valid;
        rsse_op_t              op;
        logic [RSSE_SEL_W-1:0] bit_sel;
        logic [7:0]            imm;
        logic [7:0]            operand;
    } rsse_req_t;

    typedef struct packed {
        logic signed_excess_flag;
        logic z;
        logic half_carry_flag;
        logic c;
        logic sign_carry_flag;
        logic chained_zero_flag;
    } rsse_flags_t;

    localparam rsse_flags_t RSSE_FLAGS_RST = 6'h00;

    typedef struct packed {
        logic       we;
        logic [7:0] wdata;
    } rsse_mem_t;

endpackage

// >>> design/rsse_exec.sv
// Purpose: executes rotate, subtract, skip, set and nibble-swap operations of an 8-bit core
// Assumes: decoder presents one operation with the operand already read from data memory
// Notes:   skip operations take a dummy cycle; outputs are registered
//
// What this block does
// [RQ1] rotate left into working register, bit 7 to bit 0, memory and flags kept
// [RQ2] rotate memory left via carry: old carry to bit 0, bit 7 to carry
// [RQ3] same carry rotate left, result to working register, memory kept
// [RQ4] rotate memory right in place, bit 0 to bit 7, flags kept
// [RQ5] rotate right into working register, memory and flags kept
// [RQ6] rotate memory right via carry: old carry to bit 7, bit 0 to carry
// [RQ7] same carry rotate right, result to working register, carry from bit 0
// [RQ8] working register minus operand minus inverted carry, into working register
// [RQ9] immediate borrow subtract into working register
// [RQ10] borrow subtract written back to memory
// [RQ11] plain subtracts without carry, to working register or memory
// [RQ12] subtracts update all six flags; carry set when result not negative
// [RQ13] decrement memory, skip next when result is zero, no flags
// [RQ14] decrement to working register only, skip when zero
// [RQ15] increment to memory or working register, skip when zero
// [RQ16] every skip operation takes two cycles with a dummy cycle
// [RQ17] set byte writes all ones, set bit forces one bit, no flags
// [RQ18] skip when selected bit is one, flags kept
// [RQ19] skip when selected bit is zero
// [RQ20] byte tests write operand back, skip when zero or nonzero
// [RQ21] copy operand to working register, skip when zero, no flags
// [RQ22] nibble swap to memory or working register only, flags kept
// [RQ23] a skipped instruction is dropped with no side effects, counter passes it
`timescale 1ns/10ps
module rsse_exec
    import rsse_pkg::*;
#(
    parameter int DATA_W = RSSE_DATA_W
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire rsse_req_t   req,
    output logic             ready,
    output logic [7:0]       working_register,
    output rsse_flags_t      flags,
    output rsse_mem_t        mem_wr,
    output logic             retire,
    output logic             skip_taken,
    output logic             discard
);

    // ==========================================================
    // parameter check
    if (DATA_W != RSSE_DATA_W) begin : g_bad_width
        $error("rsse_exec serves an 8-bit data path only");
    end

    // ==========================================================
    // bit select decode
    logic [7:0] bit_mask;
    for (genvar i = 0; i < RSSE_DATA_W; i++) begin : g_mask
        assign bit_mask[i] = (req.bit_sel == RSSE_SEL_W'(i));
    end

    // ==========================================================
    // state
    typedef enum logic {st_idle, st_dummy} rsse_state_t;

    rsse_state_t state;
    rsse_state_t next_state;
    logic        next_ready;
    logic [7:0]  next_working_register;
    rsse_flags_t next_flags;
    rsse_mem_t   next_mem_wr;
    logic        next_retire;
    logic        next_skip_taken;
    logic        next_discard;

    logic        accept;
    assign accept = (state == st_idle) && req.valid;

    always_comb begin
        logic [7:0] opnd;
        logic [7:0] sub_b;
        logic       borrow_in;
        logic       chained;
        logic [8:0] diff9;
        logic [4:0] half5;
        logic [7:0] rslt;
        logic       is_skip;
        logic       skip_cond;
        opnd      = req.operand;
        sub_b     = opnd;
        borrow_in = 1'b0;
        chained   = 1'b0;
        diff9     = 9'h000;
        half5     = 5'h00;
        rslt      = RSSE_ZERO;
        is_skip   = 1'b0;
        skip_cond = 1'b0;

        next_state            = state;
        next_ready            = ready;
        next_working_register = working_register;
        next_flags            = flags;
        next_mem_wr           = '0;
        next_retire           = 1'b0;
        next_skip_taken       = 1'b0;
        next_discard          = 1'b0;

        // subtract datapath shared by all six subtract forms
        if (req.op == minus_imm || req.op == borrow_minus_imm) begin
            sub_b = req.imm;
        end
        if (req.op == borrow_minus || req.op == borrow_minus_imm ||
            req.op == borrow_minus_to_mem) begin
            borrow_in = ~flags.c; // RQ8
            chained   = 1'b1;
        end
        diff9 = {1'b0, working_register} - {1'b0, sub_b} - {RSSE_ZERO, borrow_in};
        half5 = {1'b0, working_register[RSSE_NIB-1:0]} - {1'b0, sub_b[RSSE_NIB-1:0]}
              - {RSSE_NIB_ZERO, borrow_in};

        case (state)
            st_idle: begin
                if (req.valid) begin
                    next_retire = 1'b1;
                    case (req.op)
                        rotate_left: begin
                            next_mem_wr = {1'b1, opnd[RSSE_MSB-1:0], opnd[RSSE_MSB]};
                        end
                        rotate_left_to_work: begin
                            next_working_register = {opnd[RSSE_MSB-1:0], opnd[RSSE_MSB]}; // RQ1
                        end
                        rotate_left_via_carry: begin
                            next_mem_wr  = {1'b1, opnd[RSSE_MSB-1:0], flags.c}; // RQ2
                            next_flags.c = opnd[RSSE_MSB];                      // RQ2
                        end
                        rotate_left_via_carry_to_work: begin
                            next_working_register = {opnd[RSSE_MSB-1:0], flags.c}; // RQ3
                            next_flags.c          = opnd[RSSE_MSB];                // RQ3
                        end
                        rotate_right: begin
                            next_mem_wr = {1'b1, opnd[0], opnd[RSSE_MSB:1]}; // RQ4
                        end
                        rotate_right_to_work: begin
                            next_working_register = {opnd[0], opnd[RSSE_MSB:1]}; // RQ5
                        end
                        rotate_right_via_carry: begin
                            next_mem_wr  = {1'b1, flags.c, opnd[RSSE_MSB:1]}; // RQ6
                            next_flags.c = opnd[0];                           // RQ6
                        end
                        rotate_right_via_carry_to_work: begin
                            next_working_register = {flags.c, opnd[RSSE_MSB:1]}; // RQ7
                            next_flags.c          = opnd[0];                     // RQ7
                        end
                        minus_work, minus_imm, borrow_minus, borrow_minus_imm: begin
                            next_working_register = diff9[RSSE_MSB:0]; // RQ8 RQ9 RQ11
                        end
                        minus_to_mem, borrow_minus_to_mem: begin
                            next_mem_wr = {1'b1, diff9[RSSE_MSB:0]}; // RQ10 RQ11
                        end
                        dec_skip_zero: begin
                            rslt        = opnd - RSSE_ONE;
                            next_mem_wr = {1'b1, rslt}; // RQ13
                            is_skip     = 1'b1;
                            skip_cond   = (rslt == RSSE_ZERO); // RQ13
                        end
                        dec_skip_zero_to_work: begin
                            rslt                  = opnd - RSSE_ONE;
                            next_working_register = rslt; // RQ14
                            is_skip               = 1'b1;
                            skip_cond             = (rslt == RSSE_ZERO); // RQ14
                        end
                        inc_skip_zero: begin
                            rslt        = opnd + RSSE_ONE;
                            next_mem_wr = {1'b1, rslt}; // RQ15
                            is_skip     = 1'b1;
                            skip_cond   = (rslt == RSSE_ZERO); // RQ15
                        end
                        inc_skip_zero_to_work: begin
                            rslt                  = opnd + RSSE_ONE;
                            next_working_register = rslt; // RQ15
                            is_skip               = 1'b1;
                            skip_cond             = (rslt == RSSE_ZERO); // RQ15
                        end
                        skip_if_nonzero_bit: begin
                            is_skip   = 1'b1;
                            skip_cond = |(opnd & bit_mask); // RQ18
                        end
                        skip_if_zero_bit: begin
                            is_skip   = 1'b1;
                            skip_cond = ~|(opnd & bit_mask); // RQ19
                        end
                        skip_if_nonzero: begin
                            next_mem_wr = {1'b1, opnd}; // RQ20
                            is_skip     = 1'b1;
                            skip_cond   = (opnd != RSSE_ZERO); // RQ20
                        end
                        skip_if_zero: begin
                            next_mem_wr = {1'b1, opnd}; // RQ20
                            is_skip     = 1'b1;
                            skip_cond   = (opnd == RSSE_ZERO); // RQ20
                        end
                        copy_skip_zero: begin
                            next_working_register = opnd; // RQ21
                            is_skip               = 1'b1;
                            skip_cond             = (opnd == RSSE_ZERO); // RQ21
                        end
                        set_byte: begin
                            next_mem_wr = {1'b1, RSSE_ALL_ONES}; // RQ17
                        end
                        set_bit: begin
                            next_mem_wr = {1'b1, opnd | bit_mask}; // RQ17
                        end
                        nibble_exchange: begin // RQ22
                            next_mem_wr = {1'b1, opnd[RSSE_NIB-1:0], opnd[RSSE_MSB:RSSE_NIB]};
                        end
                        nibble_exchange_to_work: begin
                            next_working_register = {opnd[RSSE_NIB-1:0],
                                                     opnd[RSSE_MSB:RSSE_NIB]}; // RQ22
                        end
                        default: begin
                            next_retire = 1'b0;
                        end
                    endcase
                    // all six subtract forms share the flag update
                    if (req.op inside {minus_work, minus_imm, minus_to_mem,
                                       borrow_minus, borrow_minus_imm, borrow_minus_to_mem}) begin
                        next_flags.c                  = ~diff9[RSSE_DATA_W]; // RQ12
                        next_flags.half_carry_flag    = ~half5[RSSE_NIB];    // RQ12
                        next_flags.z                  = (diff9[RSSE_MSB:0] == RSSE_ZERO);
                        next_flags.signed_excess_flag =
                            (working_register[RSSE_MSB] ^ sub_b[RSSE_MSB]) &
                            (diff9[RSSE_MSB] ^ working_register[RSSE_MSB]); // RQ12
                        next_flags.sign_carry_flag    =
                            next_flags.signed_excess_flag ^ diff9[RSSE_MSB]; // RQ12
                        next_flags.chained_zero_flag  =
                            chained ? (next_flags.z & flags.chained_zero_flag)
                                    : next_flags.z; // RQ12
                    end
                    if (is_skip) begin
                        next_state      = st_dummy; // RQ16
                        next_ready      = 1'b0;     // RQ16
                        next_skip_taken = skip_cond;
                    end
                end
            end
            st_dummy: begin
                // the instruction offered now is dropped whole when the skip was taken
                next_state   = st_idle;
                next_ready   = 1'b1;
                next_discard = skip_taken && req.valid; // RQ23
            end
            default: begin
                next_state = st_idle;
                next_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state            <= st_idle;
            ready            <= 1'b1;
            working_register <= RSSE_ACC_RST;
            flags            <= RSSE_FLAGS_RST;
            mem_wr           <= '0;
            retire           <= 1'b0;
            skip_taken       <= 1'b0;
            discard          <= 1'b0;
        end else begin
            state            <= next_state;
            ready            <= next_ready;
            working_register <= next_working_register;
            flags            <= next_flags;
            mem_wr           <= next_mem_wr;
            retire           <= next_retire;
            skip_taken       <= next_skip_taken;
            discard          <= next_discard;
        end
    end

    // ==========================================================
    // checks
    logic        last_acc_valid;
    rsse_op_t    last_op;
    logic [7:0]  last_opnd;
    logic [7:0]  last_acc;
    logic [7:0]  last_mask;
    rsse_flags_t last_flags;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            last_acc_valid <= 1'b0;
            last_op        <= rotate_left;
            last_opnd      <= RSSE_ZERO;
            last_acc       <= RSSE_ZERO;
            last_mask      <= RSSE_ZERO;
            last_flags     <= RSSE_FLAGS_RST;
        end else begin
            last_acc_valid <= accept;
            last_op        <= req.op;
            last_opnd      <= req.operand;
            last_acc       <= working_register;
            last_mask      <= bit_mask;
            last_flags     <= flags;
        end
    end

    rol_work_a: assert property (@(posedge clock) disable iff (!resetn) // RQ1
        last_acc_valid && last_op == rotate_left_to_work |->
        working_register == {last_opnd[6:0], last_opnd[7]} && !mem_wr.we && flags == last_flags)
        else $error("rotate left to working register wrong");

    rolc_mem_a: assert property (@(posedge clock) disable iff (!resetn) // RQ2
        last_acc_valid && last_op == rotate_left_via_carry |->
        mem_wr.we && mem_wr.wdata == {last_opnd[6:0], last_flags.c} && flags.c == last_opnd[7]
        && working_register == last_acc)
        else $error("rotate left via carry wrong");

    rorc_work_a: assert property (@(posedge clock) disable iff (!resetn) // RQ7
        last_acc_valid && last_op == rotate_right_via_carry_to_work |->
        working_register == {last_flags.c, last_opnd[7:1]} && flags.c == last_opnd[0])
        else $error("rotate right via carry to working register wrong");

    ror_mem_a: assert property (@(posedge clock) disable iff (!resetn) // RQ4
        last_acc_valid && last_op == rotate_right |->
        mem_wr.we && mem_wr.wdata == {last_opnd[0], last_opnd[7:1]} && flags == last_flags)
        else $error("rotate right in memory wrong");

    sbc_diff_a: assert property (@(posedge clock) disable iff (!resetn) // RQ8
        last_acc_valid && last_op == borrow_minus |->
        working_register == last_acc - last_opnd - {7'h00, ~last_flags.c})
        else $error("borrow subtract difference wrong");

    sub_carry_a: assert property (@(posedge clock) disable iff (!resetn) // RQ12
        last_acc_valid && last_op == minus_work |->
        flags.c == (last_acc >= last_opnd) && flags.z == (last_acc == last_opnd))
        else $error("subtract carry or zero flag wrong");

    dec_skip_a: assert property (@(posedge clock) disable iff (!resetn) // RQ13
        last_acc_valid && last_op == dec_skip_zero |->
        mem_wr.wdata == last_opnd - 8'h01 && skip_taken == (last_opnd == 8'h01)
        && flags == last_flags)
        else $error("decrement and skip wrong");

    skip_two_a: assert property (@(posedge clock) disable iff (!resetn) // RQ16
        accept && req.op inside {dec_skip_zero, inc_skip_zero, skip_if_zero_bit,
                                 skip_if_nonzero_bit, skip_if_zero, copy_skip_zero} |=>
        !ready ##1 ready)
        else $error("skip operation not two cycles");

    set_bit_a: assert property (@(posedge clock) disable iff (!resetn) // RQ17
        last_acc_valid && last_op == set_bit |->
        mem_wr.we && mem_wr.wdata == (last_opnd | last_mask) && flags == last_flags)
        else $error("set bit wrong");

    drop_next_a: assert property (@(posedge clock) disable iff (!resetn) // RQ23
        skip_taken && req.valid |=> discard && !retire && !mem_wr.we
        && working_register == last_acc && flags == last_flags)
        else $error("skipped instruction had side effects");

endmodule // rsse_exec

// >>> tb/rsse_exec_tb.sv
// Purpose: self-checking bench for the rotate, subtract and skip execution unit
// Assumes: the bench model below predicts every output from the operation list
// Notes:   skip ops may offer a follow-on set_byte during the dummy cycle
`timescale 1ns/10ps
module rsse_exec_tb
    import rsse_pkg::*;
;
    logic        clock;
    logic        resetn;
    rsse_req_t   req;
    logic        ready;
    logic [7:0]  working_register;
    rsse_flags_t flags;
    rsse_mem_t   mem_wr;
    logic        retire;
    logic        skip_taken;
    logic        discard;
    int          err_total;
    int          samples_checked;
    logic [7:0]  e_acc;
    rsse_flags_t e_f;
    logic        e_we;
    logic [7:0]  e_wd;
    logic        e_skip;
    logic        e_isskip;

    rsse_exec u_rsse_exec (.clock(clock), .resetn(resetn), .req(req), .ready(ready),
        .working_register(working_register), .flags(flags), .mem_wr(mem_wr),
        .retire(retire), .skip_taken(skip_taken), .discard(discard));

    // ==========================================================
    // helpers
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic predict(rsse_op_t op, logic [2:0] bs, logic [7:0] imm, logic [7:0] m);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] b;
        logic [7:0] r;
        logic       brw;
        e_isskip = op inside {dec_skip_zero, dec_skip_zero_to_work, inc_skip_zero,
            inc_skip_zero_to_work, skip_if_nonzero_bit, skip_if_zero_bit, skip_if_nonzero,
            skip_if_zero, copy_skip_zero};
        e_we = op inside {rotate_left, rotate_left_via_carry, rotate_right, set_bit,
            rotate_right_via_carry, minus_to_mem, borrow_minus_to_mem, dec_skip_zero,
            inc_skip_zero, skip_if_nonzero, skip_if_zero, set_byte, nibble_exchange};
        r = m;
        case (op)
            rotate_left, rotate_left_to_work: r = {m[6:0], m[7]};
            rotate_right, rotate_right_to_work: r = {m[0], m[7:1]};
            rotate_left_via_carry, rotate_left_via_carry_to_work: begin
                r = {m[6:0], e_f.c};
                e_f.c = m[7];
            end
            rotate_right_via_carry, rotate_right_via_carry_to_work: begin
                r = {e_f.c, m[7:1]};
                e_f.c = m[0];
            end
            dec_skip_zero, dec_skip_zero_to_work: r = m - 8'h01;
            inc_skip_zero, inc_skip_zero_to_work: r = m + 8'h01;
            set_byte: r = 8'hFF;
            set_bit: r = m | (8'h01 << bs);
            nibble_exchange, nibble_exchange_to_work: r = {m[3:0], m[7:4]};
            default: ;
        endcase
        if (op inside {minus_work, minus_imm, minus_to_mem, borrow_minus, borrow_minus_imm,
                       borrow_minus_to_mem}) begin
            b = (op inside {minus_imm, borrow_minus_imm}) ? imm : m;
            brw = (op inside {borrow_minus, borrow_minus_imm, borrow_minus_to_mem}) && !e_f.c;
            d = {1'b0, e_acc} - {1'b0, b} - {8'h00, brw};
            h = {1'b0, e_acc[3:0]} - {1'b0, b[3:0]} - {4'h0, brw};
            r = d[7:0];
            e_f.chained_zero_flag = (r == 8'h00) &&
                (op inside {minus_work, minus_imm, minus_to_mem} || e_f.chained_zero_flag);
            e_f.signed_excess_flag = (e_acc[7] != b[7]) && (r[7] != e_acc[7]);
            e_f.sign_carry_flag = e_f.signed_excess_flag ^ r[7];
            e_f.z = (r == 8'h00);
            e_f.half_carry_flag = !h[4];
            e_f.c = !d[8];
        end
        e_skip = (op inside {dec_skip_zero, dec_skip_zero_to_work, inc_skip_zero, skip_if_zero,
            inc_skip_zero_to_work, copy_skip_zero} && r == 8'h00)
            || (op == skip_if_nonzero && r != 8'h00)
            || (op == skip_if_nonzero_bit && m[bs]) || (op == skip_if_zero_bit && !m[bs]);
        e_wd = r;
        if (op inside {rotate_left_to_work, rotate_left_via_carry_to_work, rotate_right_to_work,
            rotate_right_via_carry_to_work, minus_work, minus_imm, borrow_minus, copy_skip_zero,
            borrow_minus_imm, dec_skip_zero_to_work, inc_skip_zero_to_work,
            nibble_exchange_to_work}) e_acc = r;
    endtask

    // one operation; nxt offers a set_byte while the dummy cycle runs
    task automatic do_op(rsse_op_t op, logic [2:0] bs, logic [7:0] imm, logic [7:0] m,
                         logic nxt);
        @(posedge clock);
        req <= '{1'b1, op, bs, imm, m};
        predict(op, bs, imm, m);
        @(posedge clock);
        req <= '{nxt, set_byte, 3'h0, 8'h00, 8'h5A};
        #1;
        chk("retire", 8'h01, {7'h00, retire});
        chk("acc", e_acc, working_register);
        chk("flags", {2'b00, e_f}, {2'b00, flags});
        chk("mem_we", {7'h00, e_we}, {7'h00, mem_wr.we});
        if (e_we) chk("mem_wdata", e_wd, mem_wr.wdata);
        chk("ready", {7'h00, !e_isskip}, {7'h00, ready});
        if (e_isskip) begin
            chk("skip_taken", {7'h00, e_skip}, {7'h00, skip_taken});
            @(posedge clock);
            if (e_skip) req.valid <= 1'b0;
            #1;
            chk("discard", {7'h00, e_skip & nxt}, {7'h00, discard});
            chk("dummy_retire", 8'h00, {7'h00, retire});
            chk("dummy_we", 8'h00, {7'h00, mem_wr.we});
            if (nxt && !e_skip) begin
                @(posedge clock);
                req.valid <= 1'b0;
                #1;
                chk("held_we", 8'h01, {7'h00, mem_wr.we});
                chk("held_wdata", 8'hFF, mem_wr.wdata);
            end
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_rotate();
        do_op(minus_imm, 3'h0, 8'h00, 8'h00, 1'b0);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 8; i++) begin
                do_op(rsse_op_t'(i), 3'h0, 8'h00, k ? 8'h4E : 8'h81, 1'b0);
            end
        end
        $display("test rotate done");
    endtask

    task automatic t_subtract();
        logic [7:0] av [6] = '{8'h80, 8'h10, 8'h55, 8'h00, 8'h7F, 8'hA3};
        logic [7:0] bv [6] = '{8'h01, 8'h20, 8'h55, 8'h01, 8'hFF, 8'h5C};
        for (int i = 0; i < 6; i++) begin
            do_op(copy_skip_zero, 3'h0, 8'h00, av[i], 1'b0);
            do_op(rsse_op_t'(8 + i), 3'h0, bv[i], bv[i], 1'b0);
        end
        $display("test subtract done");
    endtask

    task automatic t_skip();
        do_op(dec_skip_zero, 3'h0, 8'h00, 8'h01, 1'b1);
        do_op(dec_skip_zero, 3'h0, 8'h00, 8'h02, 1'b1);
        do_op(dec_skip_zero_to_work, 3'h0, 8'h00, 8'h01, 1'b0);
        do_op(inc_skip_zero, 3'h0, 8'h00, 8'hFF, 1'b1);
        do_op(inc_skip_zero_to_work, 3'h0, 8'h00, 8'h00, 1'b0);
        do_op(inc_skip_zero_to_work, 3'h0, 8'h00, 8'hFF, 1'b0);
        do_op(skip_if_nonzero_bit, 3'h3, 8'h00, 8'h08, 1'b1);
        do_op(skip_if_nonzero_bit, 3'h4, 8'h00, 8'h08, 1'b1);
        do_op(skip_if_zero_bit, 3'h7, 8'h00, 8'h7F, 1'b1);
        do_op(skip_if_zero_bit, 3'h0, 8'h00, 8'h7F, 1'b0);
        do_op(skip_if_nonzero, 3'h0, 8'h00, 8'h00, 1'b1);
        do_op(skip_if_nonzero, 3'h0, 8'h00, 8'h01, 1'b0);
        do_op(skip_if_zero, 3'h0, 8'h00, 8'h00, 1'b1);
        do_op(copy_skip_zero, 3'h0, 8'h00, 8'h00, 1'b1);
        $display("test skip done");
    endtask

    task automatic t_set_swap();
        do_op(set_byte, 3'h0, 8'h00, 8'h00, 1'b0);
        do_op(set_bit, 3'h7, 8'h00, 8'h01, 1'b0);
        do_op(set_bit, 3'h0, 8'h00, 8'h80, 1'b0);
        do_op(nibble_exchange, 3'h0, 8'h00, 8'h3C, 1'b0);
        do_op(nibble_exchange_to_work, 3'h0, 8'h00, 8'hA5, 1'b0);
        $display("test set_swap done");
    endtask

    task automatic t_b2b();
        @(posedge clock);
        req <= '{1'b1, borrow_minus, 3'h0, 8'h00, 8'h30};
        predict(borrow_minus, 3'h0, 8'h00, 8'h30);
        @(posedge clock);
        req <= '{1'b1, borrow_minus_imm, 3'h0, 8'h01, 8'h00};
        #1;
        chk("b2b_acc1", e_acc, working_register);
        predict(borrow_minus_imm, 3'h0, 8'h01, 8'h00);
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
        chk("b2b_acc2", e_acc, working_register);
        chk("b2b_flags", {2'b00, e_f}, {2'b00, flags});
        $display("test b2b done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        end_sim();
    end

    initial begin
        resetn = 1'b0;
        req = '0;
        err_total = 0;
        samples_checked = 0;
        e_acc = 8'h00;
        e_f = RSSE_FLAGS_RST;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        #1;
        chk("rst_ready", 8'h01, {7'h00, ready});
        chk("rst_acc", 8'h00, working_register);
        chk("rst_flags", 8'h00, {2'b00, flags});
        chk("rst_we", 8'h00, {7'h00, mem_wr.we});
        t_rotate();
        t_subtract();
        t_skip();
        t_set_swap();
        t_b2b();
        end_sim();
    end
endmodule // rsse_exec_tb
